// file: verilog/ewa_pkg.sv
// Purpose: Shared constants for the external bus wait-state controller and arbiter
// Assumes: APB slave with 32-bit data, one register of at most 8 bits per aligned word
// Notes:   Register offsets are byte addresses
`default_nettype none
package ewa_pkg;
    localparam logic [11:0] OFF_BUS_WIDTH   = 12'h000;
    localparam logic [11:0] OFF_ACCESS_ST   = 12'h004;
    localparam logic [11:0] OFF_WAIT_EN     = 12'h008;
    localparam logic [11:0] OFF_WAIT_CTRL   = 12'h00C;
    localparam logic [11:0] OFF_BUS_RELEASE = 12'h010;
    localparam logic [11:0] OFF_CS_DIR      = 12'h014;
    localparam logic [11:0] OFF_STATUS      = 12'h018;

    localparam logic [7:0] RST_BUS_WIDTH   = 8'hFF;
    localparam logic [7:0] RST_ACCESS_ST   = 8'hFF;
    localparam logic [7:0] RST_WAIT_EN     = 8'hFF;
    localparam logic [7:0] RST_WAIT_CTRL   = 8'hF3;
    localparam logic [7:0] RST_BUS_RELEASE = 8'h00;
    localparam logic [3:0] RST_CS_DIR      = 4'h1;

    // Wait control register fields
    localparam int WCR_MODE_HI  = 3;
    localparam int WCR_MODE_LO  = 2;
    localparam int WCR_COUNT_HI = 1;
    localparam int WCR_COUNT_LO = 0;
    // Bus release register fields
    localparam int BRC_ENABLE   = 0;
    localparam int BRC_ADDR_LO  = 5;
    localparam int BRC_ADDR_HI  = 7;

    localparam logic [1:0] MODE_PROG     = 2'b00;
    localparam logic [1:0] MODE_NONE     = 2'b01;
    localparam logic [1:0] MODE_PIN1     = 2'b10;
    localparam logic [1:0] MODE_AUTO     = 2'b11;

    localparam logic [1:0] REQ_HIGH_SAMPLES = 2'd2;

    typedef enum {
        EWA_OWN_CPU,
        EWA_OWN_DMA,
        EWA_OWN_RFSH,
        EWA_OWN_EXT
    } ewa_owner_e;

    typedef enum {
        EWA_WAIT_NONE,
        EWA_WAIT_PIN0,
        EWA_WAIT_PIN1,
        EWA_WAIT_AUTO,
        EWA_WAIT_PROG
    } ewa_wmode_e;

    typedef enum {
        EWA_CYC_IDLE,
        EWA_CYC_T1,
        EWA_CYC_T2,
        EWA_CYC_TW,
        EWA_CYC_T3
    } ewa_cyc_e;
endpackage : ewa_pkg
`default_nettype wire

// file: verilog/ewa_ctrl.sv
// Purpose: Wait-state controller and four-master bus arbiter for the external bus
// Assumes: One clock; bus states advance on i_state_en; i_hold_n sampled through two flops
// Notes:   Falling-edge sampling is modelled by sampling in the state's enable cycle
//
// What this block does
// - Three-state bit, wait-control enable and mode field pick the per-area wait mode.
// - Three-state and wait-control bits per area; mode bits shared by all areas.
// - Pin mode 0 adds waits while hold pin low in T2 and after.
// - Pin mode 1 adds programmed count, then waits while hold pin low.
// - Auto-wait adds exactly programmed count if hold pin low in T2.
// - Programmable mode always adds the programmed count.
// - Reset loads all ones to area registers and F3 to wait control.
// - Priority: external master, refresh, DMA, CPU lowest.
// - Requests sampled always; grant to top requester, held until withdrawn.
// - Higher-priority requests take the bus only at release points.
// - CPU releases at cycle boundaries, never inside a split word access.
// - CPU internal work or sleep hands the bus over at once.
// - DMA releases only after a whole read-write transfer.
// - Refresh requests when due and releases when its cycle ends.
// - External release needs enable bit; held until request goes high.
// - While released, address and strobes float and grant pin is low.
// - Request pin sampled on rising edges; two high samples end release.
// - At least two states between request low and release.
// - Bus width, access-state and wait-enable writes apply from next cycle.
// - Chip-select direction and upper address writes apply from T3.
//
// Added by the designer: the register addresses and register access over APB.
`default_nettype none
module ewa_ctrl #(
    parameter int AREAS = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_state_en,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Access request from the current owner
    input  wire logic             i_acc_start,
    input  wire logic [2:0]       i_acc_area,
    input  wire logic             i_acc_ext,
    input  wire logic             i_acc_locked,
    output logic                  o_acc_done,
    output logic                  o_acc_wait,
    output logic                  o_bus_width16,
    output logic                  o_three_state,
    // Master requests
    input  wire logic             i_rfsh_req,
    input  wire logic             i_dma_req,
    input  wire logic             i_dma_xfer_end,
    input  wire logic             i_cpu_internal,
    input  wire logic             i_cpu_sleep,
    input  wire logic             i_ext_bus_request_n,
    input  wire logic             i_hold_n,
    output logic                  o_grant_cpu,
    output logic                  o_grant_dma,
    output logic                  o_grant_rfsh,
    output logic                  o_ext_grant_n,
    output logic                  o_bus_drive_en,
    output logic      [3:0]       o_chip_select_dir,
    output logic      [2:0]       o_upper_addr_en
);
    typedef struct packed {
        logic [7:0]        bus_width_ctrl_reg;
        logic [7:0]        access_state_ctrl_reg;
        logic [7:0]        wait_ctrl_enable_reg;
        logic [7:0]        wait_ctrl_reg;
        logic [7:0]        bus_release_ctrl_reg;
        logic [3:0]        cs_dir_reg;
        logic [7:0]        pend_width;
        logic [7:0]        pend_ast;
        logic [7:0]        pend_wce;
        logic [3:0]        pend_cs_dir;
        logic [2:0]        pend_upper;
        logic              pend_cfg;
        logic              pend_t3;
        logic [7:0]        act_width;
        logic [7:0]        act_ast;
        logic [7:0]        act_wce;
        logic [2:0]        upper_en;
        ewa_pkg::ewa_cyc_e cyc;
        ewa_pkg::ewa_wmode_e wmode;
        logic [1:0]        wcnt;
        logic              cnt_left;
        logic              pin_phase;
        logic [2:0]        area;
        logic              ext;
        ewa_pkg::ewa_owner_e owner;
        logic              ext_bus_request_s1;
        logic              ext_bus_request_s2;
        logic              hold_s1;
        logic              hold_s2;
        logic [1:0]        req_low_cnt;
        logic [1:0]        high_cnt;
        logic [31:0]       rdata;
    } ewa_state_s;

    ewa_state_s st_reg;
    ewa_state_s st_next;

    logic        apb_wr;
    logic        apb_rd;
    logic        boundary;
    logic        ext_req;
    logic        ext_ok;
    logic [1:0]  mode_field;
    logic [1:0]  prog_count;
    logic        hold_low;

    assign apb_wr     = psel && penable && pwrite;
    assign apb_rd     = psel && !penable && !pwrite;
    assign mode_field = {st_reg.wait_ctrl_reg[ewa_pkg::WCR_MODE_HI], st_reg.wait_ctrl_reg[ewa_pkg::WCR_MODE_LO]};
    assign prog_count = {st_reg.wait_ctrl_reg[ewa_pkg::WCR_COUNT_HI],
                         st_reg.wait_ctrl_reg[ewa_pkg::WCR_COUNT_LO]};
    assign hold_low   = !st_reg.hold_s2;
    assign ext_req    = !st_reg.ext_bus_request_s2;
    assign ext_ok     = ext_req && st_reg.bus_release_ctrl_reg[ewa_pkg::BRC_ENABLE];
    // Bus idle between cycles counts as a boundary
    assign boundary   = (st_reg.cyc == ewa_pkg::EWA_CYC_IDLE);

    always_comb begin
        st_next = st_reg;
        o_acc_done = 1'b0;

        // Two-flop synchronisers for pins
        st_next.ext_bus_request_s1 = i_ext_bus_request_n;
        st_next.ext_bus_request_s2 = st_reg.ext_bus_request_s1;
        st_next.hold_s1 = i_hold_n;
        st_next.hold_s2 = st_reg.hold_s1;

        // APB register writes
        if (apb_wr) begin
            case (paddr)
                ewa_pkg::OFF_BUS_WIDTH: begin
                    st_next.bus_width_ctrl_reg = pwdata[7:0];
                end
                ewa_pkg::OFF_ACCESS_ST: begin
                    st_next.access_state_ctrl_reg = pwdata[7:0];
                end
                ewa_pkg::OFF_WAIT_EN: begin
                    st_next.wait_ctrl_enable_reg = pwdata[7:0];
                end
                ewa_pkg::OFF_WAIT_CTRL: begin
                    st_next.wait_ctrl_reg = pwdata[7:0];
                end
                ewa_pkg::OFF_BUS_RELEASE: begin
                    st_next.bus_release_ctrl_reg = pwdata[7:0];
                end
                ewa_pkg::OFF_CS_DIR: begin
                    st_next.cs_dir_reg = pwdata[3:0];
                end
                default: begin
                end
            endcase
            // Area config staged until the next bus cycle
            st_next.pend_cfg = 1'b1;
            st_next.pend_t3  = 1'b1;
        end

        // APB read data captured in setup
        if (apb_rd) begin
            case (paddr)
                ewa_pkg::OFF_BUS_WIDTH:   st_next.rdata = {24'h00_0000, st_reg.bus_width_ctrl_reg};
                ewa_pkg::OFF_ACCESS_ST:   st_next.rdata = {24'h00_0000, st_reg.access_state_ctrl_reg};
                ewa_pkg::OFF_WAIT_EN:     st_next.rdata = {24'h00_0000, st_reg.wait_ctrl_enable_reg};
                ewa_pkg::OFF_WAIT_CTRL:   st_next.rdata = {24'h00_0000, st_reg.wait_ctrl_reg};
                ewa_pkg::OFF_BUS_RELEASE: st_next.rdata = {24'h00_0000, st_reg.bus_release_ctrl_reg};
                ewa_pkg::OFF_CS_DIR:      st_next.rdata = {28'h000_0000, st_reg.cs_dir_reg};
                ewa_pkg::OFF_STATUS:      st_next.rdata = {26'h000_0000, o_acc_wait, st_reg.wcnt,
                                                           hold_low, 2'(st_reg.owner)};
                default:                  st_next.rdata = 32'h0000_0000;
            endcase
        end

        // Staged values: area config applies when no cycle is in progress
        st_next.pend_width  = st_next.bus_width_ctrl_reg;
        st_next.pend_ast    = st_next.access_state_ctrl_reg;
        st_next.pend_wce    = st_next.wait_ctrl_enable_reg;
        st_next.pend_cs_dir = st_next.cs_dir_reg;
        st_next.pend_upper  = st_next.bus_release_ctrl_reg[ewa_pkg::BRC_ADDR_HI:ewa_pkg::BRC_ADDR_LO];
        if (st_reg.pend_cfg && boundary && !i_acc_start) begin
            st_next.act_width = st_reg.pend_width;
            st_next.act_ast   = st_reg.pend_ast;
            st_next.act_wce   = st_reg.pend_wce;
            st_next.pend_cfg  = apb_wr; // Same-cycle write keeps its pending turn
        end
        // Pin direction switches from T3 of the cycle carrying the write
        if (st_reg.pend_t3 && (st_reg.cyc == ewa_pkg::EWA_CYC_T3 || boundary)) begin
            st_next.upper_en = st_reg.pend_upper;
            st_next.pend_t3  = apb_wr;
        end

        // Bus cycle sequencer
        if (i_state_en) begin
            case (st_reg.cyc)
                ewa_pkg::EWA_CYC_IDLE: begin
                    if (i_acc_start) begin
                        st_next.cyc  = ewa_pkg::EWA_CYC_T1;
                        st_next.area = i_acc_area;
                        st_next.ext  = i_acc_ext;
                        st_next.wcnt = prog_count;
                        // Per-area bits, global mode field
                        if (!st_reg.act_ast[i_acc_area] || !i_acc_ext) begin
                            st_next.wmode = ewa_pkg::EWA_WAIT_NONE;
                        end else if (!st_reg.act_wce[i_acc_area]) begin
                            st_next.wmode = ewa_pkg::EWA_WAIT_PIN0;
                        end else begin
                            case (mode_field)
                                ewa_pkg::MODE_PROG: st_next.wmode = ewa_pkg::EWA_WAIT_PROG;
                                ewa_pkg::MODE_NONE: st_next.wmode = ewa_pkg::EWA_WAIT_NONE;
                                ewa_pkg::MODE_PIN1: st_next.wmode = ewa_pkg::EWA_WAIT_PIN1;
                                default:            st_next.wmode = ewa_pkg::EWA_WAIT_AUTO;
                            endcase
                        end
                    end
                end
                ewa_pkg::EWA_CYC_T1: begin
                    st_next.cyc = ewa_pkg::EWA_CYC_T2;
                end
                ewa_pkg::EWA_CYC_T2: begin
                    st_next.cnt_left  = (st_reg.wcnt != 2'd0);
                    st_next.pin_phase = 1'b0;
                    if (!st_reg.act_ast[st_reg.area] || !st_reg.ext) begin
                        st_next.cyc = ewa_pkg::EWA_CYC_IDLE;
                        o_acc_done  = 1'b1;
                    end else begin
                        case (st_reg.wmode)
                            ewa_pkg::EWA_WAIT_PIN0: begin
                                st_next.pin_phase = 1'b1;
                                st_next.cyc = hold_low ? ewa_pkg::EWA_CYC_TW : ewa_pkg::EWA_CYC_T3;
                            end
                            ewa_pkg::EWA_WAIT_PIN1: begin
                                // Zero count falls back to pin mode 0
                                st_next.pin_phase = (st_reg.wcnt == 2'd0);
                                st_next.cyc = (st_reg.wcnt != 2'd0 || hold_low) ?
                                              ewa_pkg::EWA_CYC_TW : ewa_pkg::EWA_CYC_T3;
                            end
                            ewa_pkg::EWA_WAIT_AUTO: begin
                                st_next.cyc = (hold_low && st_reg.wcnt != 2'd0) ?
                                              ewa_pkg::EWA_CYC_TW : ewa_pkg::EWA_CYC_T3;
                            end
                            ewa_pkg::EWA_WAIT_PROG: begin
                                st_next.cyc = (st_reg.wcnt != 2'd0) ?
                                              ewa_pkg::EWA_CYC_TW : ewa_pkg::EWA_CYC_T3;
                            end
                            default: begin
                                st_next.cyc = ewa_pkg::EWA_CYC_T3;
                            end
                        endcase
                    end
                end
                ewa_pkg::EWA_CYC_TW: begin
                    if (st_reg.pin_phase) begin
                        // Pin-driven waits last while the pin stays low
                        st_next.cyc = hold_low ? ewa_pkg::EWA_CYC_TW : ewa_pkg::EWA_CYC_T3;
                    end else begin
                        st_next.wcnt = st_reg.wcnt - 2'd1;
                        if (st_reg.wcnt == 2'd1) begin
                            if (st_reg.wmode == ewa_pkg::EWA_WAIT_PIN1 && hold_low) begin
                                st_next.pin_phase = 1'b1;
                                st_next.cyc = ewa_pkg::EWA_CYC_TW;
                            end else begin
                                // Auto-wait never extends past the count
                                st_next.cyc = ewa_pkg::EWA_CYC_T3;
                            end
                        end
                    end
                end
                ewa_pkg::EWA_CYC_T3: begin
                    st_next.cyc = ewa_pkg::EWA_CYC_IDLE;
                    o_acc_done  = 1'b1;
                end
                default: begin
                    st_next.cyc = ewa_pkg::EWA_CYC_IDLE;
                end
            endcase
        end

        // External request low-time counter for the release delay
        if (!ext_ok) begin
            st_next.req_low_cnt = 2'd0;
        end else if (i_state_en && st_reg.req_low_cnt != 2'd2) begin
            st_next.req_low_cnt = st_reg.req_low_cnt + 2'd1;
        end
        if (st_reg.ext_bus_request_s2 && st_reg.high_cnt != ewa_pkg::REQ_HIGH_SAMPLES) begin
            st_next.high_cnt = st_reg.high_cnt + 2'd1;
        end else if (!st_reg.ext_bus_request_s2) begin
            st_next.high_cnt = 2'd0;
        end

        // Arbiter: ownership changes only at release points
        case (st_reg.owner)
            ewa_pkg::EWA_OWN_EXT: begin
                // External master keeps the bus until two high samples
                if (st_reg.high_cnt == ewa_pkg::REQ_HIGH_SAMPLES) begin
                    // Next owner by priority, no idle CPU turn in between
                    st_next.owner = i_rfsh_req ? ewa_pkg::EWA_OWN_RFSH :
                                    i_dma_req  ? ewa_pkg::EWA_OWN_DMA : ewa_pkg::EWA_OWN_CPU;
                end
            end
            ewa_pkg::EWA_OWN_RFSH: begin
                if (ext_ok && st_reg.req_low_cnt == 2'd2 && boundary) begin
                    st_next.owner = ewa_pkg::EWA_OWN_EXT;
                end else if (!i_rfsh_req && boundary) begin
                    st_next.owner = i_dma_req ? ewa_pkg::EWA_OWN_DMA : ewa_pkg::EWA_OWN_CPU;
                end
            end
            ewa_pkg::EWA_OWN_DMA: begin
                // Only between whole transfers, never between read and write
                if (i_dma_xfer_end || !i_dma_req) begin
                    if (ext_ok && st_reg.req_low_cnt == 2'd2) begin
                        st_next.owner = ewa_pkg::EWA_OWN_EXT;
                    end else if (i_rfsh_req) begin
                        st_next.owner = ewa_pkg::EWA_OWN_RFSH;
                    end else if (!i_dma_req) begin
                        st_next.owner = ewa_pkg::EWA_OWN_CPU;
                    end
                end
            end
            default: begin
                // CPU: boundary not inside a split word, or at once when busy internally
                if ((boundary && !i_acc_start && !i_acc_locked) || i_cpu_internal || i_cpu_sleep) begin
                    if (ext_ok && st_reg.req_low_cnt == 2'd2) begin
                        st_next.owner = ewa_pkg::EWA_OWN_EXT;
                    end else if (i_rfsh_req) begin
                        st_next.owner = ewa_pkg::EWA_OWN_RFSH;
                    end else if (i_dma_req) begin
                        st_next.owner = ewa_pkg::EWA_OWN_DMA;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_reg <= '0;
            st_reg.bus_width_ctrl_reg    <= ewa_pkg::RST_BUS_WIDTH;
            st_reg.access_state_ctrl_reg <= ewa_pkg::RST_ACCESS_ST;
            st_reg.wait_ctrl_enable_reg  <= ewa_pkg::RST_WAIT_EN;
            st_reg.wait_ctrl_reg         <= ewa_pkg::RST_WAIT_CTRL;
            st_reg.bus_release_ctrl_reg  <= ewa_pkg::RST_BUS_RELEASE;
            st_reg.cs_dir_reg            <= ewa_pkg::RST_CS_DIR;
            st_reg.pend_width            <= ewa_pkg::RST_BUS_WIDTH;
            st_reg.pend_ast              <= ewa_pkg::RST_ACCESS_ST;
            st_reg.pend_wce              <= ewa_pkg::RST_WAIT_EN;
            st_reg.pend_cs_dir           <= ewa_pkg::RST_CS_DIR;
            st_reg.act_width             <= ewa_pkg::RST_BUS_WIDTH;
            st_reg.act_ast               <= ewa_pkg::RST_ACCESS_ST;
            st_reg.act_wce               <= ewa_pkg::RST_WAIT_EN;
            st_reg.cyc                   <= ewa_pkg::EWA_CYC_IDLE;
            st_reg.wmode                 <= ewa_pkg::EWA_WAIT_NONE;
            st_reg.owner                 <= ewa_pkg::EWA_OWN_CPU;
            st_reg.ext_bus_request_s1               <= 1'b1;
            st_reg.ext_bus_request_s2               <= 1'b1;
            st_reg.hold_s1               <= 1'b1;
            st_reg.hold_s2               <= 1'b1;
            st_reg.high_cnt              <= ewa_pkg::REQ_HIGH_SAMPLES;
        end else begin
            st_reg <= st_next;
        end
    end

    // Chip-select direction follows the T3-staged copy
    logic [3:0] cs_dir_q;
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cs_dir_q <= ewa_pkg::RST_CS_DIR;
        end else if (st_reg.pend_t3 && (st_reg.cyc == ewa_pkg::EWA_CYC_T3 || boundary)) begin
            cs_dir_q <= st_reg.pend_cs_dir;
        end
    end

    assign prdata            = st_reg.rdata;
    assign pready            = 1'b1;
    assign pslverr           = 1'b0;
    assign o_acc_wait        = (st_reg.cyc == ewa_pkg::EWA_CYC_TW);
    assign o_bus_width16     = !st_reg.act_width[i_acc_area];
    assign o_three_state     = st_reg.act_ast[i_acc_area];
    assign o_grant_cpu       = (st_reg.owner == ewa_pkg::EWA_OWN_CPU);
    assign o_grant_dma       = (st_reg.owner == ewa_pkg::EWA_OWN_DMA);
    assign o_grant_rfsh      = (st_reg.owner == ewa_pkg::EWA_OWN_RFSH);
    assign o_ext_grant_n     = (st_reg.owner != ewa_pkg::EWA_OWN_EXT);
    assign o_bus_drive_en    = (st_reg.owner != ewa_pkg::EWA_OWN_EXT);
    assign o_chip_select_dir = cs_dir_q;
    assign o_upper_addr_en   = st_reg.upper_en;
endmodule : ewa_ctrl
`default_nettype wire

// file: sim/ewa_chk_sva.sv
// Purpose: Port checks for ewa_ctrl
// Assumes: One clock domain, reset active low
// Notes:   Attached by bind below
`default_nettype none
module ewa_chk (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_dma_req,
    input wire logic i_dma_xfer_end,
    input wire logic i_cpu_sleep,
    input wire logic i_ext_bus_request_n,
    input wire logic o_acc_wait,
    input wire logic o_three_state,
    input wire logic o_grant_cpu,
    input wire logic o_grant_dma,
    input wire logic o_grant_rfsh,
    input wire logic o_ext_grant_n,
    input wire logic o_bus_drive_en
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_freed; !o_ext_grant_n ##0 i_ext_bus_request_n [*3]; endsequence
    chk_one_owner: assert property ($onehot({o_grant_cpu, o_grant_dma, o_grant_rfsh, !o_ext_grant_n}))
        else $error("owner not unique");
    chk_bus_float: assert property (!o_ext_grant_n |-> !o_bus_drive_en) else $error("bus driven");
    chk_rel_gap: assert property ($fell(o_ext_grant_n) |-> $past(!i_ext_bus_request_n, 2))
        else $error("early release");
    chk_ext_keep: assert property (!o_ext_grant_n && !i_ext_bus_request_n |=> !o_ext_grant_n)
        else $error("external owner lost bus");
    chk_rel_end: assert property (s_freed |-> ##[0:6] o_ext_grant_n) else $error("release stuck");
    chk_dma_whole: assert property (o_grant_dma && i_dma_req && !i_dma_xfer_end |=> o_grant_dma)
        else $error("dma lost bus mid transfer");
    chk_wait_area: assert property (o_acc_wait |-> o_three_state) else $error("wait in two-state");
    chk_sleep_hand: assert property (o_grant_cpu && i_cpu_sleep && i_dma_req |-> ##[1:4] !o_grant_cpu)
        else $error("sleeping cpu kept bus");
endmodule : ewa_chk
bind ewa_ctrl ewa_chk u_ewa_chk (.*);
`default_nettype wire

// file: sim/ewa_xmaster.sv
// Purpose: External bus master and slow memory hold pin
// Assumes: Bench drops i_go soon after the grant
// Notes:   Hands the bus back after eight owned cycles
`default_nettype none
module ewa_xmaster (
    input  wire logic i_clk,
    input  wire logic i_go,
    input  wire logic i_slow,
    input  wire logic i_grant_n,
    output var  logic o_req_n,
    output wire logic o_hold_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int own = 0;
    initial o_req_n = 1'b1;
    assign o_hold_n = !i_slow;
    always @(posedge i_clk) begin
        if (!o_req_n && !i_grant_n) own <= own + 1;
        if (i_go && own == 0 && i_grant_n) o_req_n <= 1'b0;
        if (own == 8) begin
            o_req_n <= 1'b1;
            own <= 0;
        end
    end
endmodule : ewa_xmaster
`default_nettype wire

// file: sim/test_ext_bus_wait_and_arbiter.sv
// Purpose: Self-checking bench for ewa_ctrl
// Assumes: Hold pin and external master come from ewa_xmaster
// Notes:   Pin modes run with hold high; sync lag cannot change their length
`default_nettype none
module test_ext_bus_wait_and_arbiter;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0, i_rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, slow = 1'b0;
    logic        i_acc_start = 1'b0, i_acc_ext = 1'b0, i_acc_locked = 1'b0, i_cpu_sleep = 1'b0, i_rfsh_req = 1'b0;
    logic        i_dma_req = 1'b0, i_dma_xfer_end = 1'b0, i_ext_bus_request_n, i_hold_n, pready, o_acc_done;
    logic        o_grant_cpu, o_grant_dma, o_grant_rfsh, o_ext_grant_n;
    logic [2:0]  i_acc_area = 3'h0;
    logic [2:0]  upa;
    logic [3:0]  own = 4'h1;
    logic [7:0]  len = 8'h00;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r, seed = 32'h0000_0012, qr[$], ql[$], qg[$];
    int          n_fail = 0, cmp_count = 0;
    wire logic [3:0] cur = {!o_ext_grant_n, o_grant_rfsh, o_grant_dma, o_grant_cpu};
    always #2 i_clk = ~i_clk;
    ewa_ctrl u_ewa_ctrl (.*, .i_state_en(1'b1), .i_cpu_internal(1'b0), .pslverr(), .o_acc_wait(), .o_bus_width16(),
        .o_three_state(), .o_bus_drive_en(), .o_chip_select_dir(), .o_upper_addr_en(upa));
    ewa_xmaster u_ewa_xmaster (.i_clk, .i_go(go), .i_slow(slow), .i_grant_n(o_ext_grant_n),
        .o_req_n(i_ext_bus_request_n), .o_hold_n(i_hold_n));
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare
    task automatic stop_test();
        $display("%0d compares, %0d wrong", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, 24'h00_0000, d};
        if (!wr) qr.push_back({24'h00_0000, d});
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic note(input logic [3:0] o);
        for (int k = 0; k < 40 && qg.size() > 0; k++) @(posedge i_clk);
        @(posedge i_clk);
        qg.push_back({28'h000_0000, o});
    endtask : note
    always @(posedge i_clk) begin
        len <= i_acc_start ? 8'h00 : len + 8'h01;
        own <= cur;
        if (psel && penable && pready && !pwrite) compare(prdata, qr.pop_front());
        if (o_acc_done === 1'b1) compare({24'h00_0000, len + 8'h01}, ql.pop_front());
        if (i_rstn && cur !== own) compare({28'h000_0000, cur}, qg.pop_front());
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        apb(1'b0, ewa_pkg::OFF_ACCESS_ST, 8'hFF);
        apb(1'b0, ewa_pkg::OFF_WAIT_EN, 8'hFF);
        apb(1'b0, ewa_pkg::OFF_WAIT_CTRL, 8'hF3);
        apb(1'b0, 12'h100, 8'h00);
        $display("test reset values done");
        repeat (24) begin
            r = seed ^ (seed << 13);
            r = r ^ (r >> 17);
            seed = r ^ (r << 5);
            r = seed;
            // Pin modes 0 and 1 keep hold high
            slow <= !(r[24] || !r[16 + r[2:0]] || r[4:3] == 2'b10);
            i_acc_locked <= r[25];
            apb(1'b1, ewa_pkg::OFF_ACCESS_ST, r[15:8]);
            apb(1'b1, ewa_pkg::OFF_WAIT_EN, r[23:16]);
            apb(1'b1, ewa_pkg::OFF_WAIT_CTRL, {4'h0, r[4:3], r[6:5]});
            {i_acc_area, i_acc_ext, i_acc_start} <= {r[2:0], r[7], 1'b1};
            ql.push_back(!r[7] || !r[8 + r[2:0]] ? 2 : !r[16 + r[2:0]] || r[4:3] == 2'b01
                || (r[4:3] == 2'b11 && !slow) ? 3 : 3 + r[6:5]);
            @(posedge i_clk);
            i_acc_start <= 1'b0;
            for (int k = 0; k < 30 && ql.size() > 0; k++) @(posedge i_clk);
        end
        $display("test wait modes done");
        i_cpu_sleep <= 1'b1;
        note(4'h2);
        i_dma_req <= 1'b1;
        repeat (12) @(posedge i_clk);
        {i_rfsh_req, go} <= 2'b11;
        repeat (12) @(posedge i_clk);
        note(4'h4);
        i_dma_xfer_end <= 1'b1;
        note(4'h8);
        apb(1'b1, ewa_pkg::OFF_BUS_RELEASE, 8'hE1);
        note(4'h4);
        go <= 1'b0;
        note(4'h2);
        i_rfsh_req <= 1'b0;
        note(4'h1);
        i_dma_req <= 1'b0;
        repeat (40) @(posedge i_clk);
        compare(qg.size() + ql.size() + qr.size(), 32'h0000_0000);
        compare({29'h000_0000, upa}, 32'h0000_0007);
        $display("test arbitration done");
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        n_fail++;
        stop_test();
    end
endmodule : test_ext_bus_wait_and_arbiter
`default_nettype wire
